// >>> verilog/omr_pkg.sv
package omr_pkg;

  // clock and gain stepping timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STEP_TIME_NS  = 1000;
  localparam int unsigned STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register numbers on page 0
  localparam logic [7:0] ADDR_RESERVED_A     = 8'h42;
  localparam logic [7:0] ADDR_LPGA_TO_HPC    = 8'h43;
  localparam logic [7:0] ADDR_LDAC_TO_HPC    = 8'h44;
  localparam logic [7:0] ADDR_RESERVED_B     = 8'h45;
  localparam logic [7:0] ADDR_RPGA_TO_HPC    = 8'h46;
  localparam logic [7:0] ADDR_RDAC_TO_HPC    = 8'h47;
  localparam logic [7:0] ADDR_HPC_LEVEL      = 8'h48;
  localparam logic [7:0] ADDR_RESERVED_C_LO  = 8'h49;
  localparam logic [7:0] ADDR_RESERVED_C_HI  = 8'h4E;
  localparam logic [7:0] ADDR_RESERVED_D     = 8'h4F;
  localparam logic [7:0] ADDR_RESERVED_E     = 8'h50;
  localparam logic [7:0] ADDR_LPGA_TO_LLO    = 8'h51;
  localparam logic [7:0] ADDR_LDAC_TO_LLO    = 8'h52;
  localparam logic [7:0] ADDR_RESERVED_F     = 8'h53;

  // field layout of routing and level registers
  localparam int unsigned ROUTE_EN_BIT = 7;
  localparam int unsigned VOL_W        = 7;
  localparam int unsigned LVL_MSB      = 7;
  localparam int unsigned LVL_LSB      = 4;
  localparam int unsigned LVL_W        = 4;
  localparam int unsigned UNMUTE_BIT   = 3;
  localparam int unsigned HIZ_BIT      = 2;
  localparam int unsigned PENDING_BIT  = 1;
  localparam int unsigned POWER_BIT    = 0;

  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_HPC_LEVEL  = 8'h06;
  localparam logic [7:0] RST_RESERVED_D = 8'h02;

  // routing register indices; the first four feed the headphone common output
  localparam int unsigned NUM_ROUTES = 6;
  localparam int unsigned NUM_HPC    = 4;
  localparam int unsigned NUM_RSVD   = 3;

endpackage

// >>> verilog/omr_gain_if.sv
`timescale 1ns/1ps
// one gain path: programmed target in, applied value and progress out
interface omr_gain_if #(
  parameter int unsigned W = 7
);
  logic [W-1:0] target;
  logic [W-1:0] applied;
  logic         busy;

  modport ctrl    (output target, input applied, input busy);
  modport stepper (input target, output applied, output busy);
endinterface

// >>> verilog/omr_step_timer.sv
`timescale 1ns/1ps
module omr_step_timer
  import omr_pkg::*;
#(
  parameter int unsigned CYCLES = STEP_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      tick
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;
  logic          tick_nxt;

  // free count only while some path is moving, saves toggling when idle
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r == LAST) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// >>> verilog/omr_gain_stepper.sv
`timescale 1ns/1ps
module omr_gain_stepper
  import omr_pkg::*;
#(
  parameter int unsigned W = 7
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic tick,
  omr_gain_if.stepper g
);
  typedef enum logic {OMR_ST_IDLE, OMR_ST_STEP} omr_step_e;

  omr_step_e    st_r;
  omr_step_e    st_nxt;
  logic [W-1:0] app_r;
  logic [W-1:0] app_nxt;

  // one code per tick avoids audible zipper steps on large changes
  always_comb begin
    st_nxt  = st_r;
    app_nxt = app_r;
    unique case (st_r)
      OMR_ST_IDLE: begin
        if (app_r != g.target) begin
          st_nxt = OMR_ST_STEP;
        end
      end
      OMR_ST_STEP: begin
        if (app_r == g.target) begin
          st_nxt = OMR_ST_IDLE;
        end else if (tick) begin
          app_nxt = (app_r < g.target) ? app_r + W'(1) : app_r - W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r  <= OMR_ST_IDLE;
      app_r <= '0;
    end else begin
      st_r  <= st_nxt;
      app_r <= app_nxt;
    end
  end

  assign g.applied = app_r;
  assign g.busy    = (st_r == OMR_ST_STEP) || (app_r != g.target);
endmodule

// >>> verilog/omr_regs.sv
`timescale 1ns/1ps
module omr_regs
  import omr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  output logic [NUM_ROUTES-1:0]  route_en,
  output logic [VOL_W-1:0]       hpc_lpga_vol,
  output logic [VOL_W-1:0]       hpc_ldac_vol,
  output logic [VOL_W-1:0]       hpc_rpga_vol,
  output logic [VOL_W-1:0]       hpc_rdac_vol,
  output logic [VOL_W-1:0]       llo_lpga_vol,
  output logic [VOL_W-1:0]       llo_ldac_vol,
  output logic [LVL_W-1:0]       hpc_level,
  output logic                   hpc_unmute,
  output logic                   hpc_hiz_when_down,
  output logic                   hpc_power_up
);

  //////////////////////////////////////////////////////////////////////////
  // address decode helpers

  // map a register number onto a routing slot; valid low if not a route
  function automatic logic [3:0] route_slot(input logic [7:0] a);
    unique case (a)
      ADDR_LPGA_TO_HPC: route_slot = 4'h8;
      ADDR_LDAC_TO_HPC: route_slot = 4'h9;
      ADDR_RPGA_TO_HPC: route_slot = 4'hA;
      ADDR_RDAC_TO_HPC: route_slot = 4'hB;
      ADDR_LPGA_TO_LLO: route_slot = 4'hC;
      ADDR_LDAC_TO_LLO: route_slot = 4'hD;
      default:          route_slot = 4'h0;
    endcase
  endfunction

  // map a register number onto a stored reserved slot
  function automatic logic [2:0] rsvd_slot(input logic [7:0] a);
    unique case (a)
      ADDR_RESERVED_A: rsvd_slot = 3'h4;
      ADDR_RESERVED_B: rsvd_slot = 3'h5;
      ADDR_RESERVED_F: rsvd_slot = 3'h6;
      default:         rsvd_slot = 3'h0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0]        route_r   [NUM_ROUTES];
  logic [7:0]        route_nxt [NUM_ROUTES];
  logic [7:0]        rsvd_r    [NUM_RSVD];
  logic [7:0]        rsvd_nxt  [NUM_RSVD];
  logic [LVL_W-1:0]  lvl_r;
  logic [LVL_W-1:0]  lvl_nxt;
  logic              unmute_r;
  logic              unmute_nxt;
  logic              hiz_r;
  logic              hiz_nxt;
  logic              pwr_r;
  logic              pwr_nxt;
  logic              pend_r;
  logic              pend_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;

  logic [3:0]        wr_route;
  logic [2:0]        wr_rsvd;
  logic [3:0]        rd_route;
  logic [2:0]        rd_rsvd;
  logic              gain_write;
  logic              any_busy;
  logic              step_tick;

  assign wr_route = route_slot(reg_addr);
  assign wr_rsvd  = rsvd_slot(reg_addr);
  assign rd_route = route_slot(reg_addr);
  assign rd_rsvd  = rsvd_slot(reg_addr);

  //////////////////////////////////////////////////////////////////////////
  // write side

  // routing registers: enable bit and volume field both plain read/write
  always_comb begin
    for (int i = 0; i < NUM_ROUTES; i++) begin
      route_nxt[i] = route_r[i];
    end
    if (reg_wr && wr_route[3]) begin
      route_nxt[wr_route[2:0]] = reg_wdata;
    end
  end

  // reserved read/write locations keep what is written, harmless to analog
  always_comb begin
    for (int i = 0; i < NUM_RSVD; i++) begin
      rsvd_nxt[i] = rsvd_r[i];
    end
    if (reg_wr && wr_rsvd[2]) begin
      rsvd_nxt[wr_rsvd[1:0]] = reg_wdata;
    end
  end

  // level control; the pending bit is read only and ignores the write
  always_comb begin
    lvl_nxt    = lvl_r;
    unmute_nxt = unmute_r;
    hiz_nxt    = hiz_r;
    pwr_nxt    = pwr_r;
    if (reg_wr && (reg_addr == ADDR_HPC_LEVEL)) begin
      // reserved codes are stored as written; the host must not use them
      lvl_nxt    = reg_wdata[LVL_MSB:LVL_LSB];
      unmute_nxt = reg_wdata[UNMUTE_BIT];
      hiz_nxt    = reg_wdata[HIZ_BIT];
      pwr_nxt    = reg_wdata[POWER_BIT];
    end
  end

  // any write that can change a gain feeding the headphone common output
  assign gain_write = reg_wr &&
                      ((wr_route[3] && (wr_route[2:0] < 3'(NUM_HPC))) ||
                       (reg_addr == ADDR_HPC_LEVEL));

  // set on the write itself so a read right after never sees a stale zero
  always_comb begin
    pend_nxt = gain_write || any_busy;
  end

  //////////////////////////////////////////////////////////////////////////
  // read side

  // one cycle read latency; unmapped and read-only reserved read zero, except 0x4F which reads 0x02
  always_comb begin
    rvalid_nxt = reg_rd;
    rdata_nxt  = rdata_r;
    if (reg_rd) begin
      rdata_nxt = RST_ZERO;
      if (rd_route[3]) begin
        rdata_nxt = route_r[rd_route[2:0]];
      end else if (rd_rsvd[2]) begin
        rdata_nxt = rsvd_r[rd_rsvd[1:0]];
      end else if (reg_addr == ADDR_HPC_LEVEL) begin
        rdata_nxt = {lvl_r, unmute_r, hiz_r, pend_r, pwr_r};
      end else if (reg_addr == ADDR_RESERVED_D) begin
        rdata_nxt = RST_RESERVED_D;
      end else if ((reg_addr >= ADDR_RESERVED_C_LO) &&
                   (reg_addr <= ADDR_RESERVED_C_HI)) begin
        rdata_nxt = RST_ZERO;
      end else if (reg_addr == ADDR_RESERVED_E) begin
        rdata_nxt = RST_ZERO;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        route_r[i] <= RST_ZERO;
      end
      for (int i = 0; i < NUM_RSVD; i++) begin
        rsvd_r[i] <= RST_ZERO;
      end
      lvl_r    <= RST_HPC_LEVEL[LVL_MSB:LVL_LSB];
      unmute_r <= RST_HPC_LEVEL[UNMUTE_BIT];
      hiz_r    <= RST_HPC_LEVEL[HIZ_BIT];
      pend_r   <= RST_HPC_LEVEL[PENDING_BIT];
      pwr_r    <= RST_HPC_LEVEL[POWER_BIT];
      rdata_r  <= RST_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        route_r[i] <= route_nxt[i];
      end
      for (int i = 0; i < NUM_RSVD; i++) begin
        rsvd_r[i] <= rsvd_nxt[i];
      end
      lvl_r    <= lvl_nxt;
      unmute_r <= unmute_nxt;
      hiz_r    <= hiz_nxt;
      pend_r   <= pend_nxt;
      pwr_r    <= pwr_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // gain ramping toward programmed values

  omr_gain_if #(.W(VOL_W)) vol_if [NUM_HPC] ();
  omr_gain_if #(.W(LVL_W)) lvl_if ();

  logic [NUM_HPC:0] busy_vec;

  // shared step timer runs only while a path still has distance to cover
  omr_step_timer #(
    .CYCLES (STEP_CYCLES)
  ) u_timer (
    .clk  (clk),
    .srst (srst),
    .run  (any_busy),
    .tick (step_tick)
  );

  for (genvar i = 0; i < NUM_HPC; i++) begin : g_vol
    assign vol_if[i].target = route_r[i][VOL_W-1:0];
    assign busy_vec[i]      = vol_if[i].busy;

    omr_gain_stepper #(
      .W (VOL_W)
    ) u_step (
      .clk  (clk),
      .srst (srst),
      .tick (step_tick),
      .g    (vol_if[i])
    );
  end

  assign lvl_if.target     = lvl_r;
  assign busy_vec[NUM_HPC] = lvl_if.busy;

  omr_gain_stepper #(
    .W (LVL_W)
  ) u_lvl_step (
    .clk  (clk),
    .srst (srst),
    .tick (step_tick),
    .g    (lvl_if)
  );

  assign any_busy = |busy_vec;

  //////////////////////////////////////////////////////////////////////////
  // outputs, all taken from flip-flops

  always_comb begin
    for (int i = 0; i < NUM_ROUTES; i++) begin
      route_en[i] = route_r[i][ROUTE_EN_BIT];
    end
  end

  // headphone common volumes come from the ramp, line output ones direct
  assign hpc_lpga_vol      = vol_if[0].applied;
  assign hpc_ldac_vol      = vol_if[1].applied;
  assign hpc_rpga_vol      = vol_if[2].applied;
  assign hpc_rdac_vol      = vol_if[3].applied;
  assign llo_lpga_vol      = route_r[4][VOL_W-1:0];
  assign llo_ldac_vol      = route_r[5][VOL_W-1:0];
  assign hpc_level         = lvl_if.applied;
  assign hpc_unmute        = unmute_r;
  assign hpc_hiz_when_down = hiz_r;
  assign hpc_power_up      = pwr_r;
  assign reg_rdata         = rdata_r;
  assign reg_rvalid        = rvalid_r;

endmodule

// >>> tb/omr_regs_properties.sv
`timescale 1ns/1ps
module omr_regs_properties
  import omr_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic [NUM_ROUTES-1:0] route_en,
  input wire logic [VOL_W-1:0]      hpc_lpga_vol,
  input wire logic [VOL_W-1:0]      llo_ldac_vol,
  input wire logic                  hpc_unmute,
  input wire logic                  hpc_hiz_when_down,
  input wire logic                  hpc_power_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // write data of the previous edge, for the control bits
  logic [7:0] wd_q;
  always_ff @(posedge clk) begin
    wd_q <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // a write to the level register, then one ramp step of the first path
  sequence lvl_wr;
    reg_wr && reg_addr == ADDR_HPC_LEVEL;
  endsequence
  sequence vol_moved;
    $changed(hpc_lpga_vol);
  endsequence

  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
  route_hold_a: assert property (!reg_wr |=> $stable(route_en))
    else $error("route changed without write");
  route_set_a: assert property (reg_wr && reg_addr == ADDR_LPGA_TO_HPC |=>
    route_en[0] == wd_q[ROUTE_EN_BIT]) else $error("route bit not taken");
  llo_vol_a: assert property (reg_wr && reg_addr == ADDR_LDAC_TO_LLO |=>
    llo_ldac_vol == wd_q[6:0] && route_en[5] == wd_q[7]) else $error("line volume wrong");
  unmute_bit_a: assert property (lvl_wr |=> hpc_unmute == wd_q[3])
    else $error("unmute bit wrong");
  hiz_bit_a: assert property (lvl_wr |=> hpc_hiz_when_down == wd_q[2])
    else $error("drive bit wrong");
  power_bit_a: assert property (lvl_wr |=> hpc_power_up == wd_q[0])
    else $error("power bit wrong");
  ramp_unit_a: assert property (vol_moved |-> hpc_lpga_vol == $past(hpc_lpga_vol) + 7'h01
    || hpc_lpga_vol == $past(hpc_lpga_vol) - 7'h01) else $error("ramp jumped");
  ramp_pace_a: assert property (vol_moved |=> $stable(hpc_lpga_vol) [*8])
    else $error("ramp too fast");
  rsvd_fixed_a: assert property (reg_rd && reg_addr == ADDR_RESERVED_D |=>
    reg_rdata == RST_RESERVED_D) else $error("fixed reserved value wrong");
  rsvd_zero_a: assert property (reg_rd && reg_addr inside {[8'h49:8'h4E]} |=>
    reg_rdata == 8'h00) else $error("read-only reserved not zero");
endmodule

// >>> tb/omr_host_model.sv
`timescale 1ns/1ps
// software side of the register port; drives only at falling edges
module omr_host_model
  import omr_pkg::*;
(
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'h00;
  end

  // one-cycle write strobe; idle bus shows inverted values, not stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_HPC_LEVEL && d[7:4] > 4'h9) return;
    if (a inside {8'h42, 8'h45, 8'h53}) return;
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // answer sits in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// >>> tb/tb_output_mixer_routing_regs.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_output_mixer_routing_regs
  import omr_pkg::*;
;
  logic clk, srst, reg_wr, reg_rd, reg_rvalid, hpc_unmute, hpc_hiz_when_down, hpc_power_up, v;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, d, a;
  logic [NUM_ROUTES-1:0] route_en;
  logic [VOL_W-1:0]      hpc_lpga_vol, hpc_ldac_vol, hpc_rpga_vol, hpc_rdac_vol;
  logic [VOL_W-1:0]      llo_lpga_vol, llo_ldac_vol;
  logic [LVL_W-1:0]      hpc_level;
  int                    error_cnt, samples_checked, cyc, i;
  logic [7:0]            rt_addr [6] = '{8'h43, 8'h44, 8'h46, 8'h47, 8'h51, 8'h52};
  logic [7:0]            rt_data [6] = '{8'h83, 8'h01, 8'h82, 8'h80, 8'hFF, 8'h2A};

  omr_regs u_dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .route_en, .hpc_lpga_vol, .hpc_ldac_vol, .hpc_rpga_vol, .hpc_rdac_vol,
    .llo_lpga_vol, .llo_ldac_vol, .hpc_level, .hpc_unmute, .hpc_hiz_when_down, .hpc_power_up);
  omr_host_model u_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard: the whole run needs well under 8000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // level register after the pending bit has settled; 0x48 holds 0x06 minus pending
  function automatic logic [7:0] rst_val(input logic [7:0] ad);
    if (ad == ADDR_HPC_LEVEL) return 8'h04;
    if (ad == ADDR_RESERVED_D) return RST_RESERVED_D;
    return 8'h00;
  endfunction

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    u_host.rd(ad, d, v);
    `CHK("read data", exp, d)
    `CHK("read valid", 1'b1, v)
  endtask

  // polls the pending bit; the ramp is 25 cycles a step, so 400 polls is ample
  task automatic wait_idle();
    for (i = 0; i < 400; i++) begin
      u_host.rd(ADDR_HPC_LEVEL, d, v);
      if (d[PENDING_BIT] === 1'b0) break;
    end
    `CHK("pending clear", 1'b0, d[PENDING_BIT])
  endtask

  initial begin
    srst = 1'b1;
    repeat (16) @(negedge clk);
    // read taken at the very first edge, before pending has cleared
    srst = 1'b0;
    u_host.reg_rd = 1'b1;
    u_host.reg_addr = ADDR_HPC_LEVEL;
    @(negedge clk);
    u_host.reg_rd = 1'b0;
    `CHK("level reset", RST_HPC_LEVEL, reg_rdata)
    `CHK("outputs reset", 6'h00, route_en)
    `CHK("drive reset", 1'b1, hpc_hiz_when_down)
    for (a = 8'h41; a < 8'h55; a++) rd_chk(a, rst_val(a));
    for (i = 0; i < 6; i++) u_host.wr(rt_addr[i], rt_data[i]);
    rd_chk(ADDR_HPC_LEVEL, 8'h06);
    for (i = 0; i < 6; i++) rd_chk(rt_addr[i], rt_data[i]);
    `CHK("routes", 6'b011101, route_en)
    `CHK("line vols", {7'h7F, 7'h2A}, {llo_lpga_vol, llo_ldac_vol})
    wait_idle();
    `CHK("hp vols", {7'h03, 7'h01, 7'h02, 7'h00},
      {hpc_lpga_vol, hpc_ldac_vol, hpc_rpga_vol, hpc_rdac_vol})
    u_host.wr(ADDR_LPGA_TO_HPC, 8'h03);
    rd_chk(ADDR_LPGA_TO_HPC, 8'h03);
    `CHK("route off", 1'b0, route_en[0])
    // top level code with every control bit set; the status bit write is dropped
    u_host.wr(ADDR_HPC_LEVEL, 8'h9D);
    rd_chk(ADDR_HPC_LEVEL, 8'h9F);
    wait_idle();
    rd_chk(ADDR_HPC_LEVEL, 8'h9D);
    `CHK("ctl on", 7'h4F, {hpc_level, hpc_unmute, hpc_hiz_when_down, hpc_power_up})
    u_host.wr(ADDR_HPC_LEVEL, 8'h02);
    wait_idle();
    rd_chk(ADDR_HPC_LEVEL, 8'h00);
    `CHK("ctl off", 7'h00, {hpc_level, hpc_unmute, hpc_hiz_when_down, hpc_power_up})
    // refused writes: read-only reserved and unmapped numbers
    for (a = 8'h49; a < 8'h51; a++) u_host.wr(a, 8'hFF);
    u_host.wr(8'h41, 8'hFF);
    for (a = 8'h49; a < 8'h51; a++) rd_chk(a, rst_val(a));
    rd_chk(8'h41, 8'h00);
    // second reset in mid-run clears live settings
    u_host.wr(ADDR_LPGA_TO_LLO, 8'h85);
    // the write must have landed, else the reset checks below prove nothing
    `CHK("route before reset", 1'b1, route_en[4])
    `CHK("line vol before reset", 7'h05, llo_lpga_vol)
    srst = 1'b1;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    `CHK("route after reset", 6'h00, route_en)
    `CHK("line vol after reset", 7'h00, llo_lpga_vol)
    rd_chk(ADDR_LPGA_TO_LLO, RST_ZERO);
    print_verdict();
  end
endmodule

bind omr_regs omr_regs_properties u_props (.clk, .srst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_rvalid, .route_en, .hpc_lpga_vol, .llo_ldac_vol, .hpc_unmute,
  .hpc_hiz_when_down, .hpc_power_up);
